//--- include/pinmux_pkg.sv
// Shared constants for the pin function multiplexer and GPIO block.
// Assumes an APB master with 32-bit data and byte addresses.
package pinmux_pkg;

   // ----------------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;                // Byte address width
   localparam int DATA_W = 32;                // APB data width

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] OFS_INUSE = 12'h000; // 1 = GPIO, 0 = peripheral
   localparam logic [11:0] OFS_ALT   = 12'h004; // 1 = alternate function
   localparam logic [11:0] OFS_LOOP  = 12'h008; // Loopback enables
   localparam logic [11:0] OFS_DIR   = 12'h00c; // 1 = GPIO output
   localparam logic [11:0] OFS_DOUT  = 12'h010; // GPIO data register
   localparam logic [11:0] OFS_DIN   = 12'h014; // Pin levels, read only
   localparam logic [11:0] OFS_PULL  = 12'h018; // Pull-up enables
   localparam logic [11:0] OFS_INSEL = 12'h01c; // Input path select
   localparam logic [11:0] OFS_IRQEN = 12'h020; // Pin event enables
   localparam logic [11:0] OFS_IRQST = 12'h024; // Sticky events, W1C
   localparam logic [11:0] OFS_PAD   = 12'h100; // Pad settings, 1 per pin

   // ----------------------------------------------------------------
   // Per-pin pad setting word
   // ----------------------------------------------------------------
   localparam int CFG_W       = 8;            // Stored width
   localparam int PAD_W       = 5;            // Bits presented to pad
   localparam int CFG_SLEW    = 0;            // Fast slew when set
   localparam int CFG_DRV_LO  = 1;            // Drive strength [2:1]
   localparam int CFG_PULL_LO = 3;            // Pull select [4:3]
   localparam int CFG_ROUT_LO = 5;            // GPIO output source [6:5]
   localparam int CFG_RIN     = 7;            // GPIO input destination

   // GPIO output source codes
   typedef enum logic [1:0]
   {
      ROUT_DATA = 2'h0,
      ROUT_A    = 2'h1,
      ROUT_B    = 2'h2,
      ROUT_C    = 2'h3
   } rout_type;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [CFG_W-1:0] RST_PAD = 8'h00; // Slow, weak, no pull
   localparam logic [31:0]      RST_REG = 32'h0000_0000;

endpackage : pinmux_pkg

//--- src/pin_cell.sv
// One pin's multiplexer: picks the pad driver and steers the pad level.
// Purely combinational; the parent registers every result.
`timescale 1ns/10ps

module pin_cell
(
   // Mode controls
   input  wire logic       gpioMode,
   input  wire logic       altMode,
   input  wire logic       loopEn,
   input  wire logic       dirOut,
   input  wire logic [1:0] routOut,
   input  wire logic       routIn,
   input  wire logic       dataOut,
   // Peripheral side
   input  wire logic       primOut,
   input  wire logic       primOe,
   input  wire logic       altOut,
   input  wire logic       altOe,
   input  wire logic [2:0] auxIn,
   // Pad side
   input  wire logic       padIn,
   // Results
   output logic            padOut,
   output logic            padOe,
   output logic            primIn,
   output logic            altIn,
   output logic            aOut,
   output logic            bOut
);
   import pinmux_pkg::*;

   // Driver choice and input steering
   always_comb
   begin
      padOut = 1'b0;
      padOe  = 1'b0;
      primIn = 1'b0;
      altIn  = 1'b0;
      aOut   = 1'b0;
      bOut   = 1'b0;
      if (gpioMode)
      begin
         // Software owns the pin; source may be an internal route
         unique case (rout_type'(routOut))
            ROUT_DATA: padOut = dataOut;
            ROUT_A:    padOut = auxIn[0];
            ROUT_B:    padOut = auxIn[1];
            ROUT_C:    padOut = auxIn[2];
         endcase
         padOe = dirOut;
         aOut  = ~routIn & padIn;
         bOut  = routIn & padIn;
      end
      else if (altMode)
      begin
         // Alternate module drives and senses
         padOut = altOut;
         padOe  = altOe;
         altIn  = loopEn ? altOut : padIn;
      end
      else
      begin
         // Primary module; loopback hides the pad from it
         padOut = primOut;
         padOe  = primOe;
         primIn = loopEn ? primOut : padIn;
      end
   end

endmodule : pin_cell

//--- src/pin_function_mux_gpio.sv
// Pin function multiplexer with GPIO, pad settings and pin events.
// Assumes an APB master, pins synchronous to clk, one pin cell per pin.
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/10ps

module pin_function_mux_gpio
#(
   parameter int               NPINS     = 32,       // Pins in the port
   parameter int               NSEL      = 4,        // Pads feeding one input
   parameter logic [NPINS-1:0] FIX_MASK  = '0,       // Pins fixed at build
   parameter logic [NPINS-1:0] FIX_GPIO  = '0,       // Fixed pin is GPIO
   parameter logic [NPINS-1:0] FIX_ALT   = '0        // Fixed pin alternate
)
(
   // Clock and reset
   input  wire logic                           clk,
   input  wire logic                           rst_b,
   // APB slave
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [pinmux_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [pinmux_pkg::DATA_W-1:0]  pwdata,
   output logic      [pinmux_pkg::DATA_W-1:0]  prdata,
   output logic                                pready,
   output logic                                pslverr,
   // Peripheral side
   input  wire logic [NPINS-1:0]               primOut,
   input  wire logic [NPINS-1:0]               primOe,
   input  wire logic [NPINS-1:0]               altOut,
   input  wire logic [NPINS-1:0]               altOe,
   output logic      [NPINS-1:0]               primIn,
   output logic      [NPINS-1:0]               altIn,
   // GPIO internal routes
   input  wire logic [NPINS-1:0]               aIn,
   input  wire logic [NPINS-1:0]               bIn,
   input  wire logic [NPINS-1:0]               cIn,
   output logic      [NPINS-1:0]               aOut,
   output logic      [NPINS-1:0]               bOut,
   // Shared internal input fed by one of several pads
   output logic                                selIn,
   // Pads
   input  wire logic [NPINS-1:0]               padIn,
   output logic      [NPINS-1:0]               padOut,
   output logic      [NPINS-1:0]               padOe,
   output logic      [NPINS-1:0]               pullupEn,
   output logic      [NPINS-1:0][pinmux_pkg::PAD_W-1:0] padSet,
   // Event to the interrupt controller
   output logic                                irq
);
   import pinmux_pkg::*;

   localparam int SELW = (NSEL > 1) ? $clog2(NSEL) : 1;

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (NPINS < 1 || NPINS > 32)
      $error("NPINS must lie in 1..32");
   if (NSEL < 2 || NSEL > NPINS)
      $error("NSEL must lie in 2..NPINS");

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic [NPINS-1:0]            inUse;    // GPIO selected
      logic [NPINS-1:0]            altSel;   // Alternate selected
      logic [NPINS-1:0]            loopEn;   // Loopback on
      logic [NPINS-1:0]            dirOut;   // GPIO output
      logic [NPINS-1:0]            dataOut;  // GPIO data register
      logic [NPINS-1:0]            pullEn;   // Pull-up enables
      logic [NPINS-1:0]            irqEn;    // Event enables
      logic [NPINS-1:0]            irqStat;  // Sticky events
      logic [NPINS-1:0][CFG_W-1:0] padCfg;   // Pad setting words
      logic [SELW-1:0]             inPath;   // Input path select
      logic [NPINS-1:0]            dataIn;   // Sampled pin levels
      logic [NPINS-1:0]            padOut;
      logic [NPINS-1:0]            padOe;
      logic [NPINS-1:0]            primIn;
      logic [NPINS-1:0]            altIn;
      logic [NPINS-1:0]            aOut;
      logic [NPINS-1:0]            bOut;
      logic                        selIn;
      logic                        irq;
      logic [DATA_W-1:0]           prdata;
      logic                        pready;
      logic                        pslverr;
   } state_type;

   state_type s_r;                            // Registered state
   state_type s_nxt;                          // Next state

   // Combinational pin cell results
   logic [NPINS-1:0] cOut, cOe, cPrim, cAlt, cA, cB;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // True when the address hits a pad setting word
   function automatic logic padHit(input logic [ADDR_W-1:0] a);
      padHit = (a >= OFS_PAD) && (a < OFS_PAD + 12'(4 * NPINS))
               && (a[1:0] == 2'h0);
   endfunction : padHit

   // Pad index of a pad setting address
   function automatic logic [4:0] padIdx(input logic [ADDR_W-1:0] a);
      padIdx = 5'(a[ADDR_W-1:2] - OFS_PAD[ADDR_W-1:2]);
   endfunction : padIdx

   // ----------------------------------------------------------------
   // Pin cells
   // ----------------------------------------------------------------
   for (genvar i = 0; i < NPINS; i++)
   begin : g_pin
      pin_cell u_cell
      (
         .gpioMode (s_r.inUse[i]),
         .altMode  (s_r.altSel[i]),
         .loopEn   (s_r.loopEn[i]),
         .dirOut   (s_r.dirOut[i]),
         .routOut  (s_r.padCfg[i][CFG_ROUT_LO +: 2]),
         .routIn   (s_r.padCfg[i][CFG_RIN]),
         .dataOut  (s_r.dataOut[i]),
         .primOut  (primOut[i]),
         .primOe   (primOe[i]),
         .altOut   (altOut[i]),
         .altOe    (altOe[i]),
         .auxIn    ({cIn[i], bIn[i], aIn[i]}),
         .padIn    (padIn[i]),
         .padOut   (cOut[i]),
         .padOe    (cOe[i]),
         .primIn   (cPrim[i]),
         .altIn    (cAlt[i]),
         .aOut     (cA[i]),
         .bOut     (cB[i])
      );
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic             setup;
      logic             wr;
      logic             known;
      logic [NPINS-1:0] wv;
      logic [NPINS-1:0] evt;
      setup = psel && !penable;
      wr    = psel && penable && pwrite && s_r.pready;
      known = 1'b0;
      wv    = pwdata[NPINS-1:0];
      // Rising level on an enabled GPIO input is an event
      evt   = padIn & ~s_r.dataIn & s_r.irqEn
              & s_r.inUse & ~s_r.dirOut;
      s_nxt = s_r;

      // Routing results, one edge after the controls
      s_nxt.padOut = cOut;
      s_nxt.padOe  = cOe;
      s_nxt.primIn = cPrim;
      s_nxt.altIn  = cAlt;
      s_nxt.aOut   = cA;
      s_nxt.bOut   = cB;
      // Out-of-range select reads as low rather than X
      s_nxt.selIn  = (int'(s_r.inPath) < NSEL)
                     ? padIn[s_r.inPath] : 1'b0;
      s_nxt.dataIn = padIn;

      // Register writes take effect at the access edge
      if (wr)
      begin
         unique case (paddr)
            OFS_INUSE:
               s_nxt.inUse  = (wv & ~FIX_MASK)
                              | (FIX_GPIO & FIX_MASK);
            OFS_ALT:
               s_nxt.altSel = (wv & ~FIX_MASK)
                              | (FIX_ALT & FIX_MASK);
            OFS_LOOP:  s_nxt.loopEn  = wv;
            OFS_DIR:   s_nxt.dirOut  = wv;
            OFS_DOUT:  s_nxt.dataOut = wv;
            OFS_PULL:  s_nxt.pullEn  = wv;
            OFS_INSEL: s_nxt.inPath  = pwdata[SELW-1:0];
            OFS_IRQEN: s_nxt.irqEn   = wv;
            default:
            begin
               if (padHit(paddr))
                  s_nxt.padCfg[padIdx(paddr)] = pwdata[CFG_W-1:0];
            end
         endcase
      end

      // Sticky events; a new event beats a same-cycle clear
      if (wr && paddr == OFS_IRQST)
         s_nxt.irqStat = (s_r.irqStat & ~wv) | evt;
      else
         s_nxt.irqStat = s_r.irqStat | evt;
      s_nxt.irq = |(s_r.irqStat & s_r.irqEn);

      // Read data is prepared in the setup cycle, so no wait states
      s_nxt.pready  = setup;
      s_nxt.pslverr = 1'b0;
      if (setup)
      begin
         known       = 1'b1;
         s_nxt.prdata = RST_REG;
         unique case (paddr)
            OFS_INUSE: s_nxt.prdata = 32'(s_r.inUse);
            OFS_ALT:   s_nxt.prdata = 32'(s_r.altSel);
            OFS_LOOP:  s_nxt.prdata = 32'(s_r.loopEn);
            OFS_DIR:   s_nxt.prdata = 32'(s_r.dirOut);
            OFS_DOUT:  s_nxt.prdata = 32'(s_r.dataOut);
            OFS_DIN:   s_nxt.prdata = 32'(s_r.dataIn);
            OFS_PULL:  s_nxt.prdata = 32'(s_r.pullEn);
            OFS_INSEL: s_nxt.prdata = 32'(s_r.inPath);
            OFS_IRQEN: s_nxt.prdata = 32'(s_r.irqEn);
            OFS_IRQST: s_nxt.prdata = 32'(s_r.irqStat);
            default:
            begin
               if (padHit(paddr))
                  s_nxt.prdata = 32'(s_r.padCfg[padIdx(paddr)]);
               else
                  known = 1'b0;
            end
         endcase
         // Unmapped address: error answer, read data zero
         s_nxt.pslverr = !known;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s_r         <= '0;
         // Fixed pins start, and stay, in their built-in function
         s_r.inUse   <= FIX_GPIO & FIX_MASK;
         s_r.altSel  <= FIX_ALT & FIX_MASK;
         s_r.padCfg  <= {NPINS{RST_PAD}};
      end
      else
         s_r <= s_nxt;
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from flip-flops
   // ----------------------------------------------------------------
   assign prdata   = s_r.prdata;
   assign pready   = s_r.pready;
   assign pslverr  = s_r.pslverr;
   assign primIn   = s_r.primIn;
   assign altIn    = s_r.altIn;
   assign aOut     = s_r.aOut;
   assign bOut     = s_r.bOut;
   assign selIn    = s_r.selIn;
   assign padOut   = s_r.padOut;
   assign padOe    = s_r.padOe;
   assign pullupEn = s_r.pullEn;
   assign irq      = s_r.irq;
   for (genvar i = 0; i < NPINS; i++)
   begin : g_pad
      assign padSet[i] = s_r.padCfg[i][PAD_W-1:0];
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   logic wrAcc;                                        // Write taken
   assign wrAcc = psel && penable && pwrite && pready;

   a_gpio_drive: assert property (
      s_r.inUse[0] && s_r.dirOut[0]
      && s_r.padCfg[0][CFG_ROUT_LO +: 2] == ROUT_DATA
      |=> padOut[0] == $past(s_r.dataOut[0]) && padOe[0])
      else $error("GPIO pin 0 not driving data bit");

   a_prim_drive: assert property (
      $past(rst_b) && !s_r.inUse[0] && !s_r.altSel[0]
      |=> padOut[0] == $past(primOut[0]) && padOe[0] == $past(primOe[0]))
      else $error("Primary function not on pin 0");

   a_alt_loop: assert property (
      !s_r.inUse[4] && s_r.altSel[4] && s_r.loopEn[4]
      |=> altIn[4] == $past(altOut[4]) && padOut[4] == $past(altOut[4]))
      else $error("Alternate loopback wrong on pin 4");

   a_input_path: assert property (
      $past(rst_b) && s_r.inPath == '0 |=> selIn == $past(padIn[0]))
      else $error("Input path select not honoured");

   a_fixed_pins: assert property (
      (s_r.inUse & FIX_MASK) == (FIX_GPIO & FIX_MASK)
      && (s_r.altSel & FIX_MASK) == (FIX_ALT & FIX_MASK))
      else $error("Fixed pin selection changed");

   a_inuse_write: assert property (
      wrAcc && paddr == OFS_INUSE
      |=> s_r.inUse == (($past(pwdata[NPINS-1:0]) & ~FIX_MASK)
                        | (FIX_GPIO & FIX_MASK)) ##1 1'b1)
      else $error("In-use write lost");

   a_pull_write: assert property (
      wrAcc && paddr == OFS_PULL
      |=> pullupEn == $past(pwdata[NPINS-1:0]))
      else $error("Pull-up write not presented");

   a_pin_read: assert property (
      psel && !penable && !pwrite && paddr == OFS_DIN
      |=> pready && prdata == 32'($past(s_r.dataIn)))
      else $error("Pin read wrong");

   a_event_irq: assert property (
      s_r.irqEn[2] && s_r.inUse[2] && !s_r.dirOut[2]
      && !s_r.dataIn[2] && padIn[2]
      |=> s_r.irqStat[2] ##1 irq)
      else $error("Pin event did not raise irq");

   a_route_a: assert property (
      s_r.inUse[1] && s_r.padCfg[1][CFG_ROUT_LO +: 2] == ROUT_A
      |=> padOut[1] == $past(aIn[1]))
      else $error("Route A not on pin 1");

   c_gpio_out: cover property (s_r.inUse[0] && s_r.dirOut[0] ##1 padOe[0]);
   c_alt_mode: cover property (!s_r.inUse[4] && s_r.altSel[4]);
   c_irq_hit:  cover property ($rose(irq));
   c_bad_addr: cover property (pslverr);

endmodule : pin_function_mux_gpio

//--- bench/pad_model.sv
// Far side of the pin mux: board pads with external drivers and pulls.
// Assumes the block's pad outputs are registered on clk.
`timescale 1ns/10ps

module pad_model
#(
   parameter int N = 32                  // Pins modelled
)
(
   // Clock
   input  wire logic         clk,
   // From the block
   input  wire logic [N-1:0] padOut,
   input  wire logic [N-1:0] padOe,
   input  wire logic [N-1:0] pullupEn,
   // Board drivers
   input  wire logic [N-1:0] extEn,
   input  wire logic [N-1:0] extVal,
   // Resolved pin levels
   output logic      [N-1:0] padIn
);
   // ------------------------------------------------------------
   // Pin resolution
   // ------------------------------------------------------------
   logic [N-1:0] lastLvl = '0;           // Level seen at the last edge

   // Floating pins flip every cycle so a stale level never passes
   always_ff @(posedge clk)
   begin
      lastLvl <= padIn;
   end

   // Block drive wins, then board drive, then the pull-up
   always_comb
   begin
      for (int i = 0; i < N; i++)
      begin
         if (padOe[i])
            padIn[i] = padOut[i];
         else if (extEn[i])
            padIn[i] = extVal[i];
         else if (pullupEn[i])
            padIn[i] = 1'h1;
         else
            padIn[i] = ~lastLvl[i];
      end
   end
endmodule : pad_model

//--- bench/pin_function_mux_gpio_tb_top.sv
// Testbench: APB register table first, then pin routing and events.
// Assumes zero-wait APB answers and the pad model on the pins.
`timescale 1ns/10ps

module pin_function_mux_gpio_tb_top;
   import pinmux_pkg::*;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        clk = 1'h0;
   logic        rst_b = 1'h0;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, primIn, altIn, aOut, bOut, padIn, padOut, padOe;
   logic [31:0] primOut = '0, primOe = '0, altOut = '0, altOe = '0;
   logic [31:0] aIn = '0, bIn = '0, cIn = '0, extEn = '0, extVal = '0;
   logic [31:0] pullupEn, rd;
   logic        pready, pslverr, selIn, irq, er;
   logic [31:0][PAD_W-1:0] padSet;
   int          num_errors = 0;
   int          n_compared = 0;
   int          waitCnt;

   // Register rows: address, write value, expected read, expected error
   typedef struct packed
   {
      logic [11:0] adr;
      logic [31:0] wr;
      logic [31:0] exp;
      logic        err;
   } row_type;
   row_type rows [11] = '{
      '{OFS_INSEL, 32'h2, 32'h2, 1'h0},
      '{OFS_PULL, 32'hf0, 32'hf0, 1'h0},
      '{OFS_PAD, 32'h1f, 32'h1f, 1'h0},
      '{12'h104, 32'h2a, 32'h2a, 1'h0},
      '{OFS_DIR, 32'h3, 32'h3, 1'h0},
      '{OFS_DOUT, 32'h1, 32'h1, 1'h0},
      '{OFS_INUSE, 32'h7, 32'h8000_0007, 1'h0},
      '{OFS_ALT, 32'h8000_0010, 32'h10, 1'h0},
      '{OFS_LOOP, 32'h110, 32'h110, 1'h0},
      '{OFS_IRQEN, 32'h4, 32'h4, 1'h0},
      '{12'h0f0, 32'h1, 32'h0, 1'h1}};

   // ------------------------------------------------------------
   // Clock, design and pads
   // ------------------------------------------------------------
   always #50 clk = ~clk;

   // Top pin locked to GPIO at build time, so the locked bits are exercised
   pin_function_mux_gpio
   #(
      .FIX_MASK (32'h8000_0000),
      .FIX_GPIO (32'h8000_0000)
   )
   u_pin_function_mux_gpio
   (
      .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .primOut(primOut),
      .primOe(primOe), .altOut(altOut), .altOe(altOe), .primIn(primIn),
      .altIn(altIn), .aIn(aIn), .bIn(bIn), .cIn(cIn), .aOut(aOut),
      .bOut(bOut), .selIn(selIn), .padIn(padIn), .padOut(padOut),
      .padOe(padOe), .pullupEn(pullupEn), .padSet(padSet), .irq(irq)
   );

   pad_model u_pad_model
   (
      .clk(clk), .padOut(padOut), .padOe(padOe), .pullupEn(pullupEn),
      .extEn(extEn), .extVal(extVal), .padIn(padIn)
   );

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic end_of_test;
      begin
         $display("errors %0d compared %0d", num_errors, n_compared);
         if (num_errors == 0 && n_compared > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask : end_of_test

   // Compare and count; unknowns never match
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string msg);
      begin
         n_compared++;
         if (got !== exp)
         begin
            num_errors++;
            $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
         end
      end
   endtask : chk

   // One APB transfer; idle edge first so psel is never set twice at once
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      begin
         @(posedge clk);
         psel    <= 1'h1;
         penable <= 1'h0;
         pwrite  <= w;
         paddr   <= a;
         pwdata  <= d;
         @(posedge clk);
         penable <= 1'h1;
         n = 0;
         do
         begin
            @(posedge clk);
            n++;
         end
         while (pready !== 1'h1 && n < 20);
         if (pready !== 1'h1)
         begin
            chk(32'h0, 32'h1, "apb timeout");
            end_of_test();
         end
         rd = prdata;
         er = pslverr;
         psel    <= 1'h0;
         penable <= 1'h0;
      end
   endtask : apb

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (4) @(posedge clk);
      rst_b <= 1'h1;
      chk(padOe, 32'h0, "reset pads");
      apb(1'h0, OFS_INUSE, 32'h0);
      chk(rd, 32'h8000_0000, "reset inuse");
      primOut <= 32'h8;
      primOe  <= 32'h8;
      altOut  <= 32'h10;
      altOe   <= 32'h10;
      aIn     <= 32'h2;
      extEn   <= 32'h4;
      foreach (rows[i])
      begin
         apb(1'h1, rows[i].adr, rows[i].wr);
         apb(1'h0, rows[i].adr, 32'h0);
         chk(rd, rows[i].exp, "readback");
         chk({31'h0, er}, {31'h0, rows[i].err}, "error");
      end
      repeat (3) @(posedge clk);
      // Pins 0,1 GPIO out, 2 GPIO in, 3 primary, 4 alternate
      chk({27'h0, padOe[4:0]}, 32'h1b, "pad enables");
      chk({27'h0, padOut[4:0]}, 32'h1b, "pad drive");
      chk({28'h0, primIn[4:3], altIn[4:3]}, 32'h6, "in");
      // Pin 8 floats, so only loopback keeps its primary input low
      chk({31'h0, primIn[8]}, 32'h0, "prim loop");
      chk(pullupEn, 32'hf0, "pull-ups");
      chk({22'h0, padSet[1], padSet[0]}, 32'h15f, "pads");
      chk({31'h0, selIn}, 32'h0, "path low");
      extVal <= 32'h4;
      for (waitCnt = 0; waitCnt < 10 && irq !== 1'h1; waitCnt++)
         @(posedge clk);
      chk({31'h0, irq}, 32'h1, "event raised");
      chk({31'h0, selIn}, 32'h1, "path high");
      apb(1'h0, OFS_DIN, 32'h0);
      chk(rd & 32'h4, 32'h4, "pin level");
      apb(1'h1, OFS_IRQST, 32'h4);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0, "event cleared");
      apb(1'h1, OFS_DOUT, 32'h0);
      repeat (3) @(posedge clk);
      chk({31'h0, padOut[0]}, 32'h0, "data low");
      end_of_test();
   end
endmodule : pin_function_mux_gpio_tb_top
